// [acsr_pkg.sv]
// package with register map, field layout and bus carriers of the status block
package acsr_pkg;
	localparam int NCH = 4;
	localparam int RES_W = 10;
	localparam int ADDR_W = 8;
	// byte offsets
	localparam logic [7:0] OFS_CHAN_ENABLE = 8'h10;
	localparam logic [7:0] OFS_CHAN_DISABLE = 8'h14;
	localparam logic [7:0] OFS_CHAN_STATUS = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	localparam logic [7:0] OFS_LAST_RESULT = 8'h20;
	localparam logic [7:0] OFS_IRQ_SET = 8'h24;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h28;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;
	localparam logic [7:0] OFS_CHAN_RESULT0 = 8'h30;
	localparam logic [7:0] OFS_RX_COUNT = 8'h50;
	localparam logic [7:0] OFS_RX_NEXT_COUNT = 8'h54;
	// status field positions
	localparam int POS_DONE = 0;
	localparam int POS_OVR = 8;
	localparam int POS_RDY = 16;
	localparam int POS_GOVR = 17;
	localparam int POS_RX_COUNT_ZERO = 18;
	localparam int POS_RXFULL = 19;
	localparam logic [19:0] STATUS_RST = 20'h0c0000;
	localparam logic [19:0] MASK_RST = 20'h00000;
	localparam logic [15:0] CNT_RST = 16'h0000;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} acsr_bus_t;

	typedef struct packed {
		logic [3:0] done;
		logic [9:0] data;
	} acsr_conv_t;
endpackage

// [acsr_top.sv]
// status, last result and interrupt mask registers of the converter
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module acsr_top
	import acsr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire acsr_bus_t bus,
	input wire acsr_conv_t conv,
	input wire logic rx_count_dec,
	input wire logic rx_next_reload,
	output logic [31:0] rdata,
	output logic irq,
	output logic [3:0] chan_enabled
);
	logic [3:0] en_r, en_nxt;
	logic [3:0] done_r, done_nxt;
	logic [3:0] ovr_r, ovr_nxt;
	logic rdy_r, rdy_nxt;
	logic govr_r, govr_nxt;
	logic rx_count_zero_r, rx_count_zero_nxt;
	logic [15:0] rcnt_r, rcnt_nxt;
	logic [15:0] ncnt_r, ncnt_nxt;
	logic [9:0] last_r, last_nxt;
	logic [9:0] cdat_r [4], cdat_nxt [4];
	logic [19:0] mask_r, mask_nxt;
	logic [31:0] rdata_nxt;
	logic irq_nxt;
	logic [19:0] status;
	logic st_rd;
	logic rcnt_wr;

	assign st_rd = bus.rd && bus.addr == OFS_STATUS;
	// a counter write supersedes a decrement landing in the same cycle
	assign rcnt_wr = bus.wr && bus.addr == OFS_RX_COUNT;

	// current status word; full flag is combinational from the counters
	always_comb begin
		status = '0;
		status[POS_DONE +: 4] = done_r;
		status[POS_OVR +: 4] = ovr_r;
		status[POS_RDY] = rdy_r;
		status[POS_GOVR] = govr_r;
		status[POS_RX_COUNT_ZERO] = rx_count_zero_r;
		status[POS_RXFULL] = rcnt_r == 16'h0000 && ncnt_r == 16'h0000;
	end

	// next state of flags, data, counters and mask
	always_comb begin
		en_nxt = en_r;
		done_nxt = done_r;
		ovr_nxt = ovr_r;
		rdy_nxt = rdy_r;
		govr_nxt = govr_r;
		rx_count_zero_nxt = rx_count_zero_r;
		rcnt_nxt = rcnt_r;
		ncnt_nxt = ncnt_r;
		last_nxt = last_r;
		mask_nxt = mask_r;
		for (int i = 0; i < 4; i++) begin
			cdat_nxt[i] = cdat_r[i];
		end
		// clears first, so events below win in the same cycle
		if (st_rd) begin
			ovr_nxt = '0;
			govr_nxt = 1'b0;
		end
		if (bus.rd && bus.addr == OFS_LAST_RESULT) begin
			rdy_nxt = 1'b0;
		end
		for (int i = 0; i < 4; i++) begin
			if (bus.rd && bus.addr == OFS_CHAN_RESULT0 + 8'(4 * i)) begin
				done_nxt[i] = 1'b0;
			end
		end
		if (bus.wr) begin
			case (bus.addr)
				OFS_CHAN_ENABLE: en_nxt = en_r | bus.wdata[3:0];
				OFS_CHAN_DISABLE: en_nxt = en_r & ~bus.wdata[3:0];
				OFS_IRQ_SET: mask_nxt = mask_r | bus.wdata[19:0];
				OFS_IRQ_CLR: mask_nxt = mask_r & ~bus.wdata[19:0];
				OFS_RX_COUNT: begin
					rcnt_nxt = bus.wdata[15:0];
					rx_count_zero_nxt = 1'b0;
				end
				OFS_RX_NEXT_COUNT: begin
					ncnt_nxt = bus.wdata[15:0];
					rx_count_zero_nxt = 1'b0;
				end
				default: ;
			endcase
		end
		// transfer counter steps; reload from next counter at zero
		if (rx_count_dec && rcnt_r != 16'h0000 && !rcnt_wr) begin
			rcnt_nxt = rcnt_r - 16'h0001;
			if (rcnt_r == 16'h0001) begin
				rx_count_zero_nxt = 1'b1;
			end
		end
		if (rx_next_reload && rcnt_nxt == 16'h0000) begin
			rcnt_nxt = ncnt_r;
			ncnt_nxt = 16'h0000;
		end
		// conversion completions; only enabled channels count
		for (int i = 0; i < 4; i++) begin
			if (conv.done[i] && en_r[i]) begin
				if (done_r[i]) begin
					ovr_nxt[i] = 1'b1;
				end
				if (rdy_r) begin
					govr_nxt = 1'b1;
				end
				done_nxt[i] = 1'b1;
				rdy_nxt = 1'b1;
				last_nxt = conv.data;
				cdat_nxt[i] = conv.data;
			end
		end
		// a disabled channel reads as not done, even against a completion
		done_nxt = done_nxt & en_nxt;
	end

	// read mux: data valid the cycle after the strobe
	always_comb begin
		rdata_nxt = '0;
		if (bus.rd) begin
			case (bus.addr)
				OFS_CHAN_STATUS: rdata_nxt = {28'h0, en_r};
				OFS_STATUS: rdata_nxt = {12'h0, status};
				OFS_LAST_RESULT: rdata_nxt = {22'h0, last_r};
				OFS_IRQ_MASK: rdata_nxt = {12'h0, mask_r};
				OFS_RX_COUNT: rdata_nxt = {16'h0, rcnt_r};
				OFS_RX_NEXT_COUNT: rdata_nxt = {16'h0, ncnt_r};
				default: begin
					for (int i = 0; i < 4; i++) begin
						if (bus.addr == OFS_CHAN_RESULT0 + 8'(4 * i)) begin
							rdata_nxt = {22'h0, cdat_r[i]};
						end
					end
				end
			endcase
		end
		irq_nxt = |(status & mask_r);
	end

	// state registers, frozen while clk_en is low
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			en_r <= '0;
			done_r <= STATUS_RST[3:0];
			ovr_r <= STATUS_RST[11:8];
			rdy_r <= STATUS_RST[16];
			govr_r <= STATUS_RST[17];
			rx_count_zero_r <= STATUS_RST[18];
			rcnt_r <= CNT_RST;
			ncnt_r <= CNT_RST;
			last_r <= '0;
			mask_r <= MASK_RST;
			rdata <= '0;
			irq <= 1'b0;
			chan_enabled <= '0;
			for (int i = 0; i < 4; i++) begin
				cdat_r[i] <= '0;
			end
		end else if (clk_en) begin
			en_r <= en_nxt;
			done_r <= done_nxt;
			ovr_r <= ovr_nxt;
			rdy_r <= rdy_nxt;
			govr_r <= govr_nxt;
			rx_count_zero_r <= rx_count_zero_nxt;
			rcnt_r <= rcnt_nxt;
			ncnt_r <= ncnt_nxt;
			last_r <= last_nxt;
			mask_r <= mask_nxt;
			rdata <= rdata_nxt;
			irq <= irq_nxt;
			chan_enabled <= en_nxt;
			for (int i = 0; i < 4; i++) begin
				cdat_r[i] <= cdat_nxt[i];
			end
		end
	end

	// checks
	property p_done_set;
		@(posedge sys_clk) disable iff (!rstn)
		clk_en && conv.done[0] && en_r[0] && !(bus.wr
			&& bus.addr == OFS_CHAN_DISABLE) |=> done_r[0];
	endproperty
	a_done_set: assert property (p_done_set) else $error("done not set");

	property p_done_en;
		@(posedge sys_clk) disable iff (!rstn) !en_r[1] |-> !done_r[1];
	endproperty
	a_done_en: assert property (p_done_en) else $error("done on disabled");

	property p_ovr_clr;
		@(posedge sys_clk) disable iff (!rstn)
		clk_en && st_rd && !(|conv.done) |=> ovr_r == 4'h0 && !govr_r;
	endproperty
	a_ovr_clr: assert property (p_ovr_clr) else $error("overrun kept");

	property p_ovr_set;
		@(posedge sys_clk) disable iff (!rstn)
		clk_en && conv.done[0] && en_r[0] && done_r[0] |=> ovr_r[0];
	endproperty
	a_ovr_set: assert property (p_ovr_set) else $error("no overrun");

	property p_rdy;
		@(posedge sys_clk) disable iff (!rstn)
		clk_en && (conv.done & en_r) != 4'h0 |=> rdy_r;
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready not set");

	property p_govr;
		@(posedge sys_clk) disable iff (!rstn)
		clk_en && rdy_r && (conv.done & en_r) != 4'h0 |=> govr_r;
	endproperty
	a_govr: assert property (p_govr) else $error("no global overrun");

	property p_rx_count_zero;
		@(posedge sys_clk) disable iff (!rstn)
		clk_en && bus.wr && bus.addr == OFS_RX_COUNT |=> !rx_count_zero_r;
	endproperty
	a_rx_count_zero: assert property (p_rx_count_zero) else $error("end flag kept");

	property p_last;
		@(posedge sys_clk) disable iff (!rstn)
		clk_en && (conv.done & en_r) != 4'h0 |=> last_r == $past(conv.data);
	endproperty
	a_last: assert property (p_last) else $error("result not loaded");

	property p_mask_set;
		@(posedge sys_clk) disable iff (!rstn)
		clk_en && bus.wr && bus.addr == OFS_IRQ_SET
		|=> (mask_r & $past(bus.wdata[19:0])) == $past(bus.wdata[19:0]);
	endproperty
	a_mask_set: assert property (p_mask_set) else $error("mask not set");

	property p_mask_clr;
		@(posedge sys_clk) disable iff (!rstn)
		clk_en && bus.wr && bus.addr == OFS_IRQ_CLR
		|=> (mask_r & $past(bus.wdata[19:0])) == 20'h00000;
	endproperty
	a_mask_clr: assert property (p_mask_clr) else $error("mask kept");

	property p_irq;
		@(posedge sys_clk) disable iff (!rstn)
		clk_en |=> irq == |($past(status) & $past(mask_r));
	endproperty
	a_irq: assert property (p_irq) else $error("irq wrong");

	// overrun on channel 0, then the status read two cycles later
	sequence s_ovr0;
		clk_en && conv.done[0] && en_r[0] && done_r[0];
	endsequence

	sequence s_st_read;
		clk_en && st_rd;
	endsequence

	property p_ovr_read;
		@(posedge sys_clk) disable iff (!rstn)
		s_ovr0 ##1 !st_rd ##1 s_st_read |=> rdata[POS_OVR];
	endproperty
	a_ovr_read: assert property (p_ovr_read)
		else $error("overrun lost");

	property p_rdy_clr;
		@(posedge sys_clk) disable iff (!rstn)
		clk_en && bus.rd && bus.addr == OFS_LAST_RESULT
			&& (conv.done & en_r) == 4'h0 |=> !rdy_r;
	endproperty
	a_rdy_clr: assert property (p_rdy_clr)
		else $error("ready kept");

	property p_rx_count_zero_set;
		@(posedge sys_clk) disable iff (!rstn)
		clk_en && rx_count_dec && rcnt_r == 16'h0001 && !rcnt_wr
		|=> rx_count_zero_r;
	endproperty
	a_rx_count_zero_set: assert property (p_rx_count_zero_set)
		else $error("end flag not set");

	property p_rxfull_rd;
		@(posedge sys_clk) disable iff (!rstn)
		clk_en && st_rd |=> rdata[POS_RXFULL]
			== ($past(rcnt_r) == 16'h0000 && $past(ncnt_r) == 16'h0000);
	endproperty
	a_rxfull_rd: assert property (p_rxfull_rd)
		else $error("full flag wrong");

	property p_cdat_keep;
		@(posedge sys_clk) disable iff (!rstn)
		!en_r[1] |=> $stable(cdat_r[1]);
	endproperty
	a_cdat_keep: assert property (p_cdat_keep)
		else $error("disabled channel result moved");

	// a low clock enable holds status, mask, last result, read data, irq and enables
	property p_freeze;
		@(posedge sys_clk) disable iff (!rstn)
		!clk_en |=> $stable(status) && $stable(mask_r) && $stable(last_r)
			&& $stable(rdata) && $stable(irq) && $stable(en_r);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while frozen");

	property p_rdata_idle;
		@(posedge sys_clk) disable iff (!rstn)
		clk_en && !bus.rd |=> rdata == 32'h00000000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data left standing");
endmodule
`default_nettype wire

// [acsr_core_model.sv]
// converter core model: completion pulses, results and receive counts
`timescale 1ns/1ps
`default_nettype none
module acsr_core_model
	import acsr_pkg::*;
(
	input wire logic sys_clk,
	output var acsr_conv_t conv,
	output logic rx_count_dec
);
	initial begin
		conv = '0;
		rx_count_dec = 1'b0;
	end

	// one-cycle completion; the bench leaves the channel enables unchanged meanwhile
	task automatic convert(input logic [1:0] ch, input logic [9:0] v);
		@(posedge sys_clk);
		conv <= '{done: 4'h1 << ch, data: v};
		@(posedge sys_clk);
		// released result lines show the inverse, never the stale value
		conv <= '{done: 4'h0, data: ~v};
	endtask

	// one receive transfer done
	task automatic rx_pulse();
		@(posedge sys_clk);
		rx_count_dec <= 1'b1;
		@(posedge sys_clk);
		rx_count_dec <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [tb.sv]
// self-checking testbench of the converter status block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import acsr_pkg::*;
	logic sys_clk, rstn, clk_en, rx_next_reload, rx_count_dec, irq;
	acsr_bus_t bus;
	acsr_conv_t conv;
	logic [31:0] rdata, d;
	logic [3:0] chan_enabled;
	int n_errors = 0;
	int num_checks = 0;

	acsr_top u_acsr_top(.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
		.bus(bus), .conv(conv), .rx_count_dec(rx_count_dec),
		.rx_next_reload(rx_next_reload), .rdata(rdata), .irq(irq),
		.chan_enabled(chan_enabled));
	acsr_core_model u_acsr_core_model(.sys_clk(sys_clk), .conv(conv),
		.rx_count_dec(rx_count_dec));

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic summarize();
		if (n_errors == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	// single-cycle strobes; the slave never stalls
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge sys_clk);
		bus <= '0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge sys_clk);
		bus <= '0;
		#1 v = rdata;
	endtask

	task automatic rchk(input string n, input logic [7:0] a,
		input logic [31:0] e);
		rd(a, d);
		chk(n, e, d);
	endtask

	task automatic t_reset();
		rchk("status", OFS_STATUS, 32'h000c0000);
		rchk("mask", OFS_IRQ_MASK, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		chk("enabled", 32'h0, {28'h0, chan_enabled});
	endtask

	task automatic t_rx();
		wr(OFS_RX_COUNT, 32'h1);
		rchk("status rx1", OFS_STATUS, 32'h0);
		u_acsr_core_model.rx_pulse();
		rchk("status rx0", OFS_STATUS, 32'h000c0000);
		wr(OFS_RX_NEXT_COUNT, 32'h0);
		rchk("status rxn", OFS_STATUS, 32'h00080000);
		wr(OFS_RX_NEXT_COUNT, 32'h2);
		wr(OFS_RX_COUNT, 32'h1);
		u_acsr_core_model.rx_pulse();
		@(posedge sys_clk);
		rx_next_reload <= 1'b1;
		@(posedge sys_clk);
		rx_next_reload <= 1'b0;
		rchk("status reload", OFS_STATUS, 32'h00040000);
		rchk("rx count", OFS_RX_COUNT, 32'h2);
		wr(OFS_RX_COUNT, 32'h0);
		rchk("status rxw", OFS_STATUS, 32'h00080000);
	endtask

	// second result lands before anyone consumed the first
	task automatic t_conv();
		wr(OFS_CHAN_ENABLE, 32'h1);
		rchk("chan status", OFS_CHAN_STATUS, 32'h1);
		chk("chan_enabled", 32'h1, {28'h0, chan_enabled});
		u_acsr_core_model.convert(2'd0, 10'h2a5);
		rchk("status done", OFS_STATUS, 32'h00090001);
		u_acsr_core_model.convert(2'd0, 10'h15a);
		rchk("status ovr", OFS_STATUS, 32'h000b0101);
		rchk("status clr", OFS_STATUS, 32'h00090001);
		rchk("last", OFS_LAST_RESULT, 32'h15a);
		rchk("status rdy", OFS_STATUS, 32'h00080001);
	endtask

	task automatic t_irq();
		wr(OFS_IRQ_SET, 32'h101);
		rchk("mask set", OFS_IRQ_MASK, 32'h101);
		chk("irq on", 32'h1, {31'h0, irq});
		wr(OFS_IRQ_CLR, 32'h1);
		rchk("mask clr", OFS_IRQ_MASK, 32'h100);
		chk("irq off", 32'h0, {31'h0, irq});
	endtask

	// channel 1 was never enabled
	task automatic t_dis();
		u_acsr_core_model.convert(2'd1, 10'h3c3);
		rd(OFS_STATUS, d);
		chk("ch1 done", 32'h0, d & 32'h2);
		rchk("ch1 data", OFS_CHAN_RESULT0 + 8'h04, 32'h0);
		rchk("unmapped", 8'h44, 32'h0);
	endtask

	// a completion while frozen must leave no trace
	task automatic t_freeze();
		@(posedge sys_clk);
		clk_en <= 1'b0;
		u_acsr_core_model.convert(2'd0, 10'h0f0);
		@(posedge sys_clk);
		clk_en <= 1'b1;
		rchk("frozen status", OFS_STATUS, 32'h00080001);
		rchk("frozen last", OFS_LAST_RESULT, 32'h15a);
		chk("frozen enabled", 32'h1, {28'h0, chan_enabled});
		rchk("ch0 data", OFS_CHAN_RESULT0, 32'h15a);
		rchk("done cleared", OFS_STATUS, 32'h00080000);
	endtask

	// reset again mid-run, with flags, mask and enables changed
	task automatic t_rst2();
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
	endtask

	initial begin
		rstn = 1'b0;
		clk_en = 1'b1;
		bus = '0;
		rx_next_reload = 1'b0;
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		t_rx();
		t_conv();
		t_irq();
		t_freeze();
		t_dis();
		t_rst2();
		summarize();
	end

	// hang guard
	initial begin
		repeat (2000) @(posedge sys_clk);
		n_errors++;
		summarize();
	end
endmodule
`default_nettype wire
